// >>> src/siread_fifo.v
`timescale 1ns/100ps
`default_nettype none
module siread_fifo #(
  parameter WIDTH = 1,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // Write side
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  // Read side
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire do_wr;
  wire do_rd;
  localparam [AW:0] FULL_COUNT = DEPTH;
  integer i;
  assign in_ready_out = (count != FULL_COUNT);
  assign out_valid_out = (count != {(AW+1){1'b0}});
  assign out_data_out = mem[rd_ptr];
  assign do_wr = in_valid_in & in_ready_out;
  assign do_rd = out_valid_out & out_ready_in;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= {WIDTH{1'b0}};
      end
    end else begin
      if (do_wr) begin
        mem[wr_ptr] <= in_data_in;
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_wr && !do_rd) begin
        count <= count + {{AW{1'b0}}, 1'b1};
      end else if (do_rd && !do_wr) begin
        count <= count - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // siread_fifo
`default_nettype wire

// >>> src/siread_identifier_access_port.v
`timescale 1ns/100ps
`default_nettype none
`include "siread_regs.vh"
module siread_identifier_access_port (
  // Clock and reset
  input wire clk_in,
  input wire reset_n_in,
  // Controls from user logic
  input wire load_in,
  input wire shift_in,
  input wire serial_in,
  // Serial output is its own flop, loaded from the next value's MSB in step with the register
  output reg serial_out,
  // Buffered stream of shifted-out bits
  output reg stream_valid_out,
  input wire stream_ready_in,
  output reg stream_data_out,
  // Back-pressure: low when the bit buffer is full, and from reset until the edge after rst_sync rises
  output reg shift_ready_out
);
  ////////////////////////////////////////////////////////////////
  // Reset release
  reg rst_meta;
  reg rst_sync;
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end
  ////////////////////////////////////////////////////////////////
  // Identifier and shift register
  // Constant only; no path writes it
  wire [`SIREAD_ID_MSB:0] device_identifier = `SIREAD_ID_VALUE;
  reg [`SIREAD_ID_MSB:0] shreg;
  reg [`SIREAD_ID_MSB:0] next_shreg;
  wire fifo_in_ready;
  // Refused shifts leave the register untouched
  wire shift_take = shift_in & ~load_in & shift_ready_out & fifo_in_ready;
  always @* begin
    next_shreg = shreg;
    if (load_in) begin
      next_shreg = device_identifier;
    end else if (shift_take) begin
      next_shreg = {shreg[`SIREAD_ID_MSB-1:0], serial_in};
    end
  end
  always @(posedge clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      shreg <= `SIREAD_SR_RESET;
      serial_out <= 1'b0;
    end else begin
      shreg <= next_shreg;
      serial_out <= next_shreg[`SIREAD_ID_MSB];
    end
  end
  ////////////////////////////////////////////////////////////////
  // Bit buffer: each shift pushes the bit leaving the output
  wire fifo_out_valid;
  wire fifo_out_data;
  wire fifo_pop = stream_ready_in | ~stream_valid_out;
  siread_fifo #(
    .WIDTH(`SIREAD_FIFO_WIDTH),
    .DEPTH(`SIREAD_FIFO_DEPTH),
    .AW(`SIREAD_FIFO_AW)
  ) u_fifo (
    .clk_in(clk_in),
    .rst_n_in(rst_sync),
    .in_valid_in(shift_take),
    .in_ready_out(fifo_in_ready),
    .in_data_in(shreg[`SIREAD_ID_MSB]),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(fifo_out_data)
  );
  // Occupancy mirror: the ready flag comes from a flop that resets low, then matches the buffer in the same cycle
  reg [`SIREAD_FIFO_AW:0] buf_fill;
  reg [`SIREAD_FIFO_AW:0] next_buf_fill;
  wire buf_pop = fifo_out_valid & fifo_pop;
  always @* begin
    next_buf_fill = buf_fill;
    if (shift_take && !buf_pop) begin
      next_buf_fill = buf_fill + {{`SIREAD_FIFO_AW{1'b0}}, 1'b1};
    end else if (buf_pop && !shift_take) begin
      next_buf_fill = buf_fill - {{`SIREAD_FIFO_AW{1'b0}}, 1'b1};
    end
  end
  always @(posedge clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      stream_valid_out <= 1'b0;
      stream_data_out <= 1'b0;
      shift_ready_out <= 1'b0;
      buf_fill <= {(`SIREAD_FIFO_AW+1){1'b0}};
    end else begin
      buf_fill <= next_buf_fill;
      shift_ready_out <= (next_buf_fill != `SIREAD_FIFO_FULL);
      if (fifo_pop) begin
        stream_valid_out <= fifo_out_valid;
        stream_data_out <= fifo_out_data;
      end
    end
  end
endmodule // siread_identifier_access_port
`default_nettype wire

// >>> src/siread_regs.vh
`ifndef SIREAD_REGS_VH
`define SIREAD_REGS_VH
`define SIREAD_ID_WIDTH 57
`define SIREAD_ID_MSB 56
// Arbitrary neutral identifier value
`define SIREAD_ID_VALUE 57'h0a5_5a5a_c3c3_3c3c
`define SIREAD_SR_RESET 57'h000_0000_0000_0000
`define SIREAD_SAME_ID_MAX 32
`define SIREAD_FIFO_WIDTH 1
`define SIREAD_FIFO_DEPTH 16
`define SIREAD_FIFO_AW 4
`define SIREAD_FIFO_FULL 5'h10
`endif

// >>> tb/serial_identifier_readout_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "siread_regs.vh"
`define CHK(a,e) begin checks++; if ((a)!==(e)) begin failures++; $display("mismatch %0t %h %h",$time,a,e); end end
module serial_identifier_readout_tb_top;
  logic clk_in=0, reset_n_in=0, load_in=0, shift_in=0, serial_in=0, stall=1, ok, e;
  wire serial_out, stream_valid_out, stream_ready_in, stream_data_out, shift_ready_out;
  logic [56:0] r;
  logic q[$];
  int checks=0, failures=0, i;
  always #5 clk_in = !clk_in;
  siread_identifier_access_port u_siread_identifier_access_port(.*);
  siread_consumer u_siread_consumer(.clk_in, .stall_in(stall), .stream_ready_in);
  task end_of_test;
    $display("checks=%0d failures=%0d", checks, failures);
    if (checks > 0 && failures == 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task op(input logic l, s);
    ok = shift_ready_out;
    load_in = l;
    shift_in = s;
    serial_in = 1'($urandom);
    @(posedge clk_in);
    #6 if (l) r = `SIREAD_ID_VALUE;
    else if (s && ok) begin
      q.push_back(r[56]);
      r = {r[55:0], serial_in};
    end
    `CHK(serial_out, r[56])
  endtask
  always @(posedge clk_in) if (stream_valid_out && stream_ready_in) begin
    e = q.size() ? q.pop_front() : 1'bx;
    `CHK(stream_data_out, e)
  end
  initial begin
    void'($urandom(82));
    repeat (5) @(posedge clk_in);
    #6 reset_n_in = 1;
    repeat (3) @(posedge clk_in);
    #6 stall = 0;
    op(1, 1);
    op(0, 0);
    repeat (80) op(0, 1'($urandom % 4 != 0));
    $display("shift test done");
    stall = 1;
    op(1, 0);
    for (i = 0; i < 40 && shift_ready_out; i++) op(0, 1);
    if (i == 40) begin
      failures++;
      end_of_test;
    end
    `CHK(q.size(), `SIREAD_FIFO_DEPTH + 1)
    repeat (4) op(0, 1);
    stall = 0;
    repeat (60) op(0, 0);
    `CHK(q.size(), 0)
    $display("fill test done");
    end_of_test;
  end
endmodule // serial_identifier_readout_tb_top
`default_nettype wire

// >>> tb/siread_checker.sv
`timescale 1ns/100ps
`default_nettype none
`include "siread_regs.vh"
module siread_checker(input wire clk_in, reset_n_in, load_in, shift_in, serial_in, serial_out,
  stream_valid_out, stream_ready_in, stream_data_out, shift_ready_out);
  localparam logic [56:0] ID = `SIREAD_ID_VALUE;
  logic [3:0] rst_pipe;
  // The design releases its own reset two edges late; stay quiet until its outputs have left reset
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) rst_pipe <= 4'h0;
    else rst_pipe <= {rst_pipe[2:0], 1'b1};
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_pipe[3]);
  AST_LOAD: assert property (load_in |=> serial_out == ID[56]) else $error("load");
  AST_BOTH:
    assert property (load_in && shift_in ##1 !(load_in|shift_in) |=> serial_out == ID[56]) else $error("both");
  AST_SHIFT:
    assert property (load_in ##1 !load_in && shift_in && shift_ready_out |=> serial_out == ID[55]) else $error("shift");
  AST_HOLD: assert property (!(load_in|shift_in) |=> $stable(serial_out)) else $error("hold");
  AST_FULL: assert property (!load_in && !shift_ready_out |=> $stable(serial_out)) else $error("full");
  AST_PUSH: assert property ($rose(stream_valid_out) |-> $past(shift_in && !load_in, 2)) else $error("push");
  AST_STALL:
    assert property (stream_valid_out && !stream_ready_in |=> stream_valid_out && $stable(stream_data_out))
      else $error("stall");
  AST_FULLV: assert property (!shift_ready_out |-> stream_valid_out) else $error("fullv");
  cover property (load_in && shift_in);
  cover property (!shift_ready_out && shift_in);
  cover property (stream_valid_out && stream_ready_in);
endmodule // siread_checker
bind siread_identifier_access_port siread_checker u_siread_checker(.*);
`default_nettype wire

// >>> tb/siread_consumer.sv
`timescale 1ns/100ps
`default_nettype none
module siread_consumer(input wire logic clk_in, stall_in, output logic stream_ready_in);
  initial stream_ready_in = 1'b0;
  always @(posedge clk_in) stream_ready_in <= #1 !stall_in && !stream_ready_in;
endmodule // siread_consumer
`default_nettype wire
